// file: cfg_pkg.sv
`default_nettype none
package cfg_pkg;
  localparam int CFG_W = 16;
  localparam int ADDR_W = 32;
  // Field positions within both configuration copies
  localparam int LOCK_BIT = 11;
  localparam int BLEN_LO = 0;
  localparam int BLEN_HI = 1;
  // Bit of the command-address word that selects a linear burst
  localparam int CA_LINEAR_BIT = 45;
  localparam int CA_W = 48;
  // Burst length codes
  localparam logic [1:0] BLEN_RSVD = 2'h0;
  localparam logic [1:0] BLEN_64 = 2'h1;
  localparam logic [1:0] BLEN_16 = 2'h2;
  localparam logic [1:0] BLEN_32 = 2'h3;
  // Factory value of the nonvolatile copy
  localparam logic [15:0] NV_FACTORY = 16'h88BB;
  // Wrap masks on the word address
  localparam logic [4:0] WRAP_MASK_16 = 5'h07;
  localparam logic [4:0] WRAP_MASK_32 = 5'h0F;
  localparam logic [4:0] WRAP_MASK_64 = 5'h1F;
endpackage
`default_nettype wire

// file: burst_addr_gen.sv
`default_nettype none
module burst_addr_gen
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic linear,
  input wire logic [1:0] blen,
  input wire logic step,
  output logic [ADDR_W-1:0] word_addr
);
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [4:0] mask_r, mask_nxt;
  logic lin_r, lin_nxt;
  logic [ADDR_W-1:0] inc;
  logic [ADDR_W-1:0] m32;

  // -----------------------------
  // Address sequencing
  // -----------------------------
  // Wrapped steps keep the upper bits and roll the masked low bits
  always_comb begin
    addr_nxt = addr_r;
    mask_nxt = mask_r;
    lin_nxt = lin_r;
    inc = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
    m32 = {{(ADDR_W-5){1'b0}}, mask_r};
    if (start) begin
      addr_nxt = start_addr;
      lin_nxt = linear;
      unique case (blen)
        BLEN_16: mask_nxt = WRAP_MASK_16; // R09
        BLEN_32: mask_nxt = WRAP_MASK_32; // R10
        BLEN_64: mask_nxt = WRAP_MASK_64; // R11
        default: mask_nxt = WRAP_MASK_32;
      endcase
    end else if (step) begin
      if (lin_r) begin
        addr_nxt = inc; // R08
      end else begin
        addr_nxt = (addr_r & ~m32) | (inc & m32);
      end
    end
  end

  // Registers the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
      mask_r <= WRAP_MASK_32;
      lin_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      mask_r <= mask_nxt;
      lin_r <= lin_nxt;
    end
  end

  assign word_addr = addr_r;
endmodule
`default_nettype wire

// file: config_source_and_burst_wrap.sv
// Operation
// R01: Nonvolatile program or erase acts only after power-on or hardware reset; the code's rst_n reloads NV_FACTORY into both copies.
// R02: Writing the volatile copy changes interface behaviour at once.
// R03: Nonvolatile lock set while unlocked: unlocked until reset, then both zero.
// R04: Reset after nonvolatile lock programmed clears both lock bits.
// R05: Software reset leaves the source multiplexer as it was.
// R06: Nonvolatile change leaves an already written volatile copy untouched.
// R07: Nonvolatile program before any volatile write also loads the volatile copy.
// R08: Command-address bit 45 set gives linear burst, increment without wrap.
// R09: Code 10 wraps within aligned eight words.
// R10: Code 11 wraps within aligned sixteen words.
// R11: Code 01 wraps within aligned thirty-two words.
// R12: Reset selects nonvolatile source; volatile write switches to volatile.
// R13: Lock bit zero blocks volatile writes and nonvolatile program or erase.
// R14: Host picks burst type per transaction and expects active wrap size.
`default_nettype none
module config_source_and_burst_wrap
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_reset,
  input wire logic sw_reset,
  input wire logic vol_write,
  input wire logic [cfg_pkg::CFG_W-1:0] vol_wdata,
  input wire logic nv_program,
  input wire logic nv_erase,
  input wire logic [cfg_pkg::CFG_W-1:0] nv_wdata,
  input wire logic burst_start,
  input wire logic [cfg_pkg::CA_W-1:0] command_address_word,
  input wire logic burst_step,
  output logic [cfg_pkg::ADDR_W-1:0] burst_word_addr,
  output logic [cfg_pkg::CFG_W-1:0] active_config,
  output logic [cfg_pkg::CFG_W-1:0] volatile_config_copy,
  output logic [cfg_pkg::CFG_W-1:0] nonvolatile_config_copy,
  output logic config_source_mux,
  output logic write_refused
);
  import cfg_pkg::*;

  // Nonvolatile array contents do not survive rst_n; rst_n reloads the factory value
  logic [CFG_W-1:0] nv_r, nv_nxt;
  // Value in force for the interface, captured at reset
  logic [CFG_W-1:0] vol_r, vol_nxt;
  logic loaded_r, loaded_nxt;
  logic pend_r, pend_nxt;
  logic ref_r, ref_nxt;
  logic unlocked;
  logic [CFG_W-1:0] nv_after;

  // -----------------------------
  // Configuration copies
  // -----------------------------
  // Lock judged from the copy in force, so a fresh nonvolatile lock
  // does not bite until the next reset
  always_comb begin
    nv_nxt = nv_r;
    vol_nxt = vol_r;
    loaded_nxt = loaded_r;
    pend_nxt = pend_r;
    ref_nxt = 1'b0;
    unlocked = vol_r[LOCK_BIT]; // R13
    nv_after = nv_program ? (nv_r & nv_wdata) : {CFG_W{1'b1}};
    if (hw_reset) begin
      // Source returns to nonvolatile and its value comes into force
      loaded_nxt = 1'b0; // R12
      pend_nxt = 1'b0;
      vol_nxt = nv_r; // R01
      if (!nv_r[LOCK_BIT]) begin
        vol_nxt[LOCK_BIT] = 1'b0; // R04
      end
      if (pend_r) begin
        nv_nxt[LOCK_BIT] = 1'b0; // R03
        vol_nxt[LOCK_BIT] = 1'b0; // R03
      end
    end else if (sw_reset) begin
      vol_nxt = vol_r; // R05
    end else if (vol_write || nv_program || nv_erase) begin
      if (!unlocked) begin
        ref_nxt = 1'b1; // R13
      end else if (vol_write) begin
        vol_nxt = vol_wdata; // R02
        loaded_nxt = 1'b1; // R12
      end else begin
        nv_nxt = nv_after;
        // An erase that sets the lock again cancels a pending lock
        pend_nxt = pend_r && !nv_after[LOCK_BIT];
        if (nv_r[LOCK_BIT] && !nv_after[LOCK_BIT]) begin
          pend_nxt = 1'b1; // R03
        end
        if (!loaded_r && nv_program) begin
          vol_nxt = nv_after; // R07
          vol_nxt[LOCK_BIT] = vol_r[LOCK_BIT]; // R03
        end
        // R06: loaded volatile copy is left alone
      end
    end
  end

  // Registers the copies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_r <= NV_FACTORY;
      vol_r <= NV_FACTORY;
      loaded_r <= 1'b0;
      pend_r <= 1'b0;
      ref_r <= 1'b0;
    end else begin
      nv_r <= nv_nxt;
      vol_r <= vol_nxt;
      loaded_r <= loaded_nxt;
      pend_r <= pend_nxt;
      ref_r <= ref_nxt;
    end
  end

  // -----------------------------
  // Outputs and burst engine
  // -----------------------------
  // The copy in force drives the interface
  assign active_config = vol_r; // R01
  assign volatile_config_copy = vol_r;
  assign nonvolatile_config_copy = nv_r;
  assign config_source_mux = loaded_r;
  assign write_refused = ref_r;

  burst_addr_gen u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .start(burst_start),
    .start_addr(command_address_word[ADDR_W-1:0]),
    .linear(command_address_word[CA_LINEAR_BIT]), // R08
    .blen(vol_r[BLEN_HI:BLEN_LO]),
    .step(burst_step),
    .word_addr(burst_word_addr)
  );
endmodule
`default_nettype wire

// file: cfg_properties.sv
`default_nettype none
// ----
// Source selection and burst order checks
// ----
module cfg_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_reset,
  input wire logic sw_reset,
  input wire logic vol_write,
  input wire logic [15:0] vol_wdata,
  input wire logic nv_program,
  input wire logic burst_start,
  input wire logic [47:0] command_address_word,
  input wire logic burst_step,
  input wire logic [31:0] burst_word_addr,
  input wire logic [15:0] active_config,
  input wire logic [15:0] nonvolatile_config_copy,
  input wire logic config_source_mux,
  input wire logic write_refused
);
  logic lin_r, vw, ok;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Burst type of the burst in progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lin_r <= 1'h0;
    else if (burst_start) lin_r <= command_address_word[45];
  end
  // Volatile write taken, and taken while unlocked
  assign vw = vol_write && !hw_reset && !sw_reset && !nv_program;
  assign ok = vw && active_config[11];
  AST_VOL: assert property (ok |=> active_config == $past(vol_wdata)
    && config_source_mux) else $error("volatile write lost");
  AST_SRC_NV: assert property (hw_reset |=> !config_source_mux)
    else $error("source not nonvolatile");
  AST_SW: assert property (sw_reset && !hw_reset |=>
    $stable(config_source_mux)) else $error("source moved");
  AST_LOCK: assert property (vw && !active_config[11] |=>
    write_refused && $stable(active_config)) else $error("lock ignored");
  AST_NV: assert property (config_source_mux && nv_program &&
    !hw_reset && !sw_reset && !vol_write |=> $stable(active_config))
    else $error("early change");
  AST_HW: assert property (hw_reset |=>
    active_config == $past(nonvolatile_config_copy)) else $error("hw load");
  AST_LIN: assert property (burst_step && !burst_start && lin_r |=>
    burst_word_addr == $past(burst_word_addr) + 32'h0000_0001)
    else $error("linear step");
  AST_WRAP: assert property (burst_step && !burst_start && !lin_r |=>
    burst_word_addr[31:5] == $past(burst_word_addr[31:5]))
    else $error("wrap escaped");
  cover property (ok);
  cover property (vw && !active_config[11]);
  cover property (burst_step && !lin_r);
endmodule
bind config_source_and_burst_wrap cfg_properties i_props (.*);
`default_nettype wire

// file: host_burst_model.sv
`default_nettype none
// ----
// Host issuing one read burst at a time
// ----
module host_burst_model (
  input wire logic clk,
  input wire logic [31:0] burst_word_addr,
  output logic burst_start,
  output logic [47:0] command_address_word,
  output logic burst_step
);
  logic [31:0] got [32];
  initial begin
    burst_start = 1'h0;
    burst_step = 1'h0;
    command_address_word = 48'h0000_0000_0000;
  end
  // Start, then step each cycle and record each address
  task automatic burst(input logic [31:0] a, input logic ln, input int n);
    @(posedge clk);
    burst_start <= 1'h1;
    command_address_word <= {2'h0, ln, 13'h0000, a};
    @(posedge clk);
    burst_start <= 1'h0;
    burst_step <= 1'h1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      got[i] = burst_word_addr;
    end
    burst_step <= 1'h0;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench import cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] bl; logic ln; logic [7:0] a;} row_t;
  logic clk, rst_n, hw_reset, sw_reset, vol_write, nv_program, nv_erase;
  logic burst_start, burst_step, config_source_mux, write_refused;
  logic [15:0] vol_wdata, nv_wdata, active_config;
  logic [15:0] volatile_config_copy, nonvolatile_config_copy;
  logic [47:0] command_address_word;
  logic [31:0] burst_word_addr, a;
  logic [4:0] m;
  int error_cnt = 0, check_count = 0;
  row_t rows [7] = '{'{2'h0, 1'h1, 8'h03}, '{2'h2, 1'h0, 8'h02},
    '{2'h2, 1'h0, 8'h0C}, '{2'h3, 1'h0, 8'h0A}, '{2'h3, 1'h0, 8'h1E},
    '{2'h1, 1'h0, 8'h03}, '{2'h1, 1'h0, 8'h2E}};
  config_source_and_burst_wrap i_dut (.*);
  host_burst_model i_host (.*);
  // ----
  // Clock and tasks
  // ----
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // One-cycle strobes: hw, sw, volatile write, program, erase
  task automatic op(input logic [4:0] k, input logic [15:0] d);
    @(posedge clk);
    {hw_reset, sw_reset, vol_write, nv_program, nv_erase} <= k;
    vol_wdata <= d;
    nv_wdata <= d;
    @(posedge clk);
    {hw_reset, sw_reset, vol_write, nv_program, nv_erase} <= 5'h00;
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    {rst_n, hw_reset, sw_reset, vol_write, nv_program, nv_erase} = 6'h00;
    vol_wdata = 16'h0000;
    nv_wdata = 16'h0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    cmp(active_config, NV_FACTORY);
    op(5'h02, 16'hFFFE);
    cmp(volatile_config_copy, NV_FACTORY & 16'hFFFE);
    foreach (rows[r]) begin
      op(5'h04, {NV_FACTORY[15:2], rows[r].bl});
      a = {24'hA5_A5A5, rows[r].a};
      m = rows[r].bl == BLEN_16 ? WRAP_MASK_16 :
        rows[r].bl == BLEN_64 ? WRAP_MASK_64 : WRAP_MASK_32;
      i_host.burst(a, rows[r].ln, 32);
      for (int i = 0; i < 32; i++) begin
        cmp(i_host.got[i], rows[r].ln ? a + i :
          {a[31:5], a[4:0] & ~m | 5'(a[4:0] + i) & m});
      end
      $display("burst row %0d done", r);
    end
    cmp(config_source_mux, 1'h1);
    op(5'h01, 16'h0000);
    op(5'h02, 16'hF7FF);
    cmp(volatile_config_copy, {NV_FACTORY[15:2], 2'h1});
    cmp(active_config[11], 1'h1);
    op(5'h08, 16'h0000);
    cmp(config_source_mux, 1'h1);
    op(5'h10, 16'h0000);
    cmp({config_source_mux, active_config}, 17'h0_F7FF);
    cmp(nonvolatile_config_copy, 16'hF7FF);
    op(5'h04, 16'hFFFF);
    cmp({write_refused, active_config}, 17'h1_F7FF);
    $display("config tests done");
    final_report();
  end
endmodule
`default_nettype wire
